// file: logic/rad_alias_match.sv
// Address compare against all alias entries with remap lookup
`timescale 1ns/10ps
module rad_alias_match
  import rad_pkg::*;
(
  rad_cfg_if.match cfg
);

  logic [NUM_ENTRIES-1:0] hit;

  for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_cmp
    // A zero alias field never matches, so address 0 cannot reach a target
    assign hit[g] = (cfg.entries[g][ALIAS_MSB:ALIAS_LSB] != ALIAS_OFF) && // [RULE3]
                    (cfg.entries[g][ALIAS_MSB:ALIAS_LSB] == cfg.q_addr);  // [RULE1]
  end

  // Lowest index wins when software programs the same alias twice
  always_comb begin
    cfg.q_hit     = 1'b0;
    cfg.q_idx     = 3'h0;
    cfg.q_phys    = 7'h00;
    cfg.q_autoack = 1'b0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        cfg.q_hit     = 1'b1;
        cfg.q_idx     = 3'(i);
        cfg.q_phys    = cfg.phys[i]; // [RULE2]
        cfg.q_autoack = cfg.entries[i][AUTOACK_BIT]; // [RULE4]
      end
    end
  end

endmodule

// file: logic/rad_alias_store.sv
// Six alias entries held in flip-flops with one write port
`timescale 1ns/10ps
module rad_alias_store
  import rad_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  rad_cfg_if.store  cfg
);

  typedef struct packed {
    logic [NUM_ENTRIES-1:0][7:0] entries;
  } rad_store_t;

  rad_store_t q, d;

  always_comb begin
    d = q;
    if (cfg.wr_en && (int'(cfg.wr_idx) < NUM_ENTRIES)) begin
      d.entries[cfg.wr_idx] = cfg.wr_data; // [RULE7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        q.entries[i] <= ALIAS_RST; // [RULE7]
      end
    end else begin
      q <= d;
    end
  end

  assign cfg.entries = q.entries;

endmodule

// file: logic/rad_cfg_if.sv
// Interface joining the alias store, the matcher and the control logic
`timescale 1ns/10ps
interface rad_cfg_if;
  import rad_pkg::*;
  logic [NUM_ENTRIES-1:0][7:0] entries;
  logic                        wr_en;
  logic [2:0]                  wr_idx;
  logic [7:0]                  wr_data;
  logic [6:0]                  q_addr;
  logic [NUM_ENTRIES-1:0][6:0] phys;
  logic                        q_hit;
  logic [2:0]                  q_idx;
  logic [6:0]                  q_phys;
  logic                        q_autoack;

  modport store (input wr_en, wr_idx, wr_data, output entries);
  modport match (input entries, q_addr, phys, output q_hit, q_idx, q_phys, q_autoack);
  modport ctrl  (output wr_en, wr_idx, wr_data, q_addr, phys,
                 input entries, q_hit, q_idx, q_phys, q_autoack);
endinterface

// file: logic/rad_decoder_top.sv
// Remote target alias decoder with AXI4-Lite register access
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps

// Summary of operation
// [RULE1] Entries hold 7-bit alias; addresses compared
// [RULE2] Matched address replaced by paired physical address
// [RULE3] Zero alias field disables its entry
// [RULE4] Auto-ack bit acknowledges writes without remote
// [RULE5] Auto-ack per entry, ignores remote acknowledge
// [RULE6] Six entries at consecutive indices 0x65-0x6a
// [RULE7] Fields readable, writable, reset to zero
// [RULE8] Physical address forwarded over control channel
// [RULE9] Unmatched addresses pass on unchanged locally
module rad_decoder_top
  import rad_pkg::*;
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [31:0]                 s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [31:0]                 s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        txn_valid,
  output logic                             txn_ready,
  input  wire logic [6:0]                  txn_addr,
  input  wire logic                        txn_read,
  input  wire logic [NUM_ENTRIES-1:0][6:0] physical_target_addr_entry,
  output logic                             bcc_valid,
  input  wire logic                        bcc_ready,
  output logic [6:0]                       bcc_addr,
  output logic                             bcc_read,
  output logic [2:0]                       bcc_entry,
  input  wire logic                        bcc_resp_valid,
  input  wire logic                        bcc_resp_ack,
  output logic                             local_ack_valid,
  output logic                             local_ack,
  output logic                             pass_valid,
  output logic [6:0]                       pass_addr
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    rad_state_t  st;
    logic        aw_held;
    logic [31:0] awaddr;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic [6:0]  bcc_addr;
    logic        bcc_read;
    logic [2:0]  bcc_entry;
    logic        remote_ack;
    logic        ack_valid;
    logic        ack_ok;
    logic        pass_valid;
    logic [6:0]  pass_addr;
    logic        last_hit;
    logic [2:0]  last_idx;
  } rad_top_t;

  rad_top_t q, d;

  rad_cfg_if cfg ();

  // ----------------------------------------------------------------------
  // Entry storage and matching
  // ----------------------------------------------------------------------
  rad_alias_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (cfg)
  );

  rad_alias_match u_match (
    .cfg (cfg)
  );

  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        aw_have;
  logic        w_have;
  logic        do_wr;
  logic [31:0] aw_eff;
  logic [7:0]  wd_eff;
  logic        wstb_eff;
  rad_sel_t    wsel;
  rad_sel_t    rsel;
  logic        txn_take;
  logic [7:0]  status_val;

  // ----------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------
  // Address and data are held separately so either may arrive first
  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready  = !q.w_held && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign aw_have       = q.aw_held || aw_take;
  assign w_have        = q.w_held || w_take;
  assign do_wr         = aw_have && w_have && !q.bvalid;
  assign aw_eff        = q.aw_held ? q.awaddr : s_axi_awaddr;
  assign wd_eff        = q.w_held ? q.wdata : s_axi_wdata[7:0];
  assign wstb_eff      = q.w_held ? q.wstb : s_axi_wstrb[0];
  assign wsel          = rad_decode(aw_eff);
  assign rsel          = rad_decode(s_axi_araddr);
  assign txn_ready     = (q.st == RAD_IDLE);
  assign txn_take      = txn_valid && txn_ready;

  // Only the low byte lane carries a register, upper lanes are ignored
  assign cfg.wr_en   = do_wr && wsel.alias_hit && wstb_eff; // [RULE6]
  assign cfg.wr_idx  = wsel.idx;
  assign cfg.wr_data = wd_eff; // [RULE7]
  assign cfg.q_addr  = txn_addr;
  assign cfg.phys    = physical_target_addr_entry;

  always_comb begin
    status_val                           = 8'h00;
    status_val[STAT_BUSY_BIT]            = (q.st != RAD_IDLE);
    status_val[STAT_IDX_LSB+:3]          = q.last_idx;
    status_val[STAT_HIT_BIT]             = q.last_hit;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d            = q;
    d.ack_valid  = 1'b0;
    d.pass_valid = 1'b0;

    if (aw_take) begin
      d.aw_held = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (w_take) begin
      d.w_held = 1'b1;
      d.wdata  = s_axi_wdata[7:0];
      d.wstb   = s_axi_wstrb[0];
    end
    if (do_wr) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (wsel.alias_hit || wsel.stat_hit) ? RESP_OKAY : RESP_SLVERR;
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    if (ar_take) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      if (rsel.alias_hit) begin
        d.rdata = cfg.entries[rsel.idx]; // [RULE7]
      end else if (rsel.stat_hit) begin
        d.rdata = status_val;
      end else begin
        d.rdata = 8'h00;
        d.rresp = RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    case (q.st)
      RAD_IDLE: begin
        if (txn_take) begin
          d.last_hit = cfg.q_hit;
          if (cfg.q_hit) begin
            d.st        = RAD_FWD;
            d.bcc_addr  = cfg.q_phys; // [RULE2]
            d.bcc_read  = txn_read;
            d.bcc_entry = cfg.q_idx;
            d.last_idx  = cfg.q_idx;
            if (cfg.q_autoack && !txn_read) begin
              // Local host is released at once, remote answer is dropped
              d.ack_valid  = 1'b1; // [RULE4]
              d.ack_ok     = 1'b1;
              d.remote_ack = 1'b0; // [RULE5]
            end else begin
              d.remote_ack = 1'b1;
            end
          end else begin
            d.pass_valid = 1'b1; // [RULE9]
            d.pass_addr  = txn_addr;
          end
        end
      end
      RAD_FWD: begin
        if (bcc_ready) begin
          d.st = RAD_WAIT; // [RULE8]
        end
      end
      RAD_WAIT: begin
        if (bcc_resp_valid) begin
          d.st = RAD_IDLE;
          if (q.remote_ack) begin
            d.ack_valid = 1'b1;
            d.ack_ok    = bcc_resp_ack;
          end
        end
      end
      default: begin
        d.st = RAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q    <= '0;
      q.st <= RAD_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rresp     = q.rresp;
  assign s_axi_rdata     = {24'h000000, q.rdata};
  assign bcc_valid       = (q.st == RAD_FWD); // [RULE8]
  assign bcc_addr        = q.bcc_addr;
  assign bcc_read        = q.bcc_read;
  assign bcc_entry       = q.bcc_entry;
  assign local_ack_valid = q.ack_valid;
  assign local_ack       = q.ack_ok;
  assign pass_valid      = q.pass_valid;
  assign pass_addr       = q.pass_addr;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_take_hit;
    txn_valid && txn_ready && cfg.q_hit;
  endsequence

  sequence s_auto_write;
    txn_valid && txn_ready && cfg.q_hit && cfg.q_autoack && !txn_read;
  endsequence

  property p_alias_compare;
    cfg.q_hit |-> (cfg.entries[cfg.q_idx][ALIAS_MSB:ALIAS_LSB] == txn_addr);
  endproperty
  a_alias_compare: assert property (p_alias_compare) // [RULE1]
    else $error("hit entry alias differs from address");

  property p_remap;
    s_take_hit |=> bcc_valid && (bcc_addr == $past(physical_target_addr_entry[cfg.q_idx]))
               && (bcc_entry == $past(cfg.q_idx));
  endproperty
  a_remap: assert property (p_remap) // [RULE2]
    else $error("forwarded address is not the paired physical one");

  property p_zero_disabled;
    cfg.q_hit |-> (cfg.entries[cfg.q_idx][ALIAS_MSB:ALIAS_LSB] != ALIAS_OFF);
  endproperty
  a_zero_disabled: assert property (p_zero_disabled) // [RULE3]
    else $error("disabled entry matched");

  // The far side may take the request at once, so only the first cycle is fixed
  property p_auto_ack;
    s_auto_write |=> local_ack_valid && local_ack && bcc_valid;
  endproperty
  a_auto_ack: assert property (p_auto_ack) // [RULE4]
    else $error("auto acknowledge not given at once");

  property p_auto_ignores_remote;
    (q.st == RAD_WAIT) && !q.remote_ack && bcc_resp_valid |=> !local_ack_valid;
  endproperty
  a_auto_ignores_remote: assert property (p_auto_ignores_remote) // [RULE5]
    else $error("remote answer reached host after auto acknowledge");

  property p_reg_read;
    ar_take && rsel.alias_hit |=> s_axi_rvalid && (s_axi_rresp == RESP_OKAY)
                              && (s_axi_rdata[7:0] == $past(cfg.entries[rsel.idx]));
  endproperty
  a_reg_read: assert property (p_reg_read) // [RULE6]
    else $error("alias register read returned wrong value");

  property p_reset_zero;
    !$past(aresetn) |-> (cfg.entries == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [RULE7]
    else $error("alias entries not zero after reset");

  property p_fwd_hold;
    bcc_valid && !bcc_ready |=> bcc_valid && $stable(bcc_addr) && $stable(bcc_read);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold) // [RULE8]
    else $error("forward request dropped or changed before taken");

  property p_pass_through;
    txn_valid && txn_ready && !cfg.q_hit |=> pass_valid && !bcc_valid
                                          && (pass_addr == $past(txn_addr));
  endproperty
  a_pass_through: assert property (p_pass_through) // [RULE9]
    else $error("unmatched address not passed unchanged");

endmodule

// file: logic/rad_pkg.sv
// Shared constants, types and decode function for the remote alias decoder
package rad_pkg;

  // ----------------------------------------------------------------------
  // Alias entries
  // ----------------------------------------------------------------------
  localparam int          NUM_ENTRIES   = 6;
  localparam int          ALIAS_MSB     = 7;
  localparam int          ALIAS_LSB     = 1;
  localparam int          AUTOACK_BIT   = 0;
  localparam logic [7:0]  ALIAS_RST     = 8'h00;
  localparam logic [6:0]  ALIAS_OFF     = 7'h00;

  // ----------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ALIAS0_IDX    = 8'h65;
  localparam logic [7:0]  ALIAS1_IDX    = 8'h66;
  localparam logic [7:0]  ALIAS2_IDX    = 8'h67;
  localparam logic [7:0]  ALIAS3_IDX    = 8'h68;
  localparam logic [7:0]  ALIAS4_IDX    = 8'h69;
  localparam logic [7:0]  ALIAS5_IDX    = 8'h6a;
  localparam logic [7:0]  STATUS_IDX    = 8'h80;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_IDX_LSB  = 1;
  localparam int          STAT_HIT_BIT  = 4;

  // ----------------------------------------------------------------------
  // AXI4-Lite responses
  // ----------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    RAD_IDLE = 3'h1,
    RAD_FWD  = 3'h2,
    RAD_WAIT = 3'h4
  } rad_state_t;

  typedef struct packed {
    logic       alias_hit;
    logic       stat_hit;
    logic [2:0] idx;
  } rad_sel_t;

  // Word-aligned decode shared by the write and read paths
  function automatic rad_sel_t rad_decode(input logic [31:0] addr);
    rad_sel_t   s;
    logic [7:0] word;
    logic       clean;
    word        = addr[9:2];
    clean       = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0);
    s.alias_hit = clean && (word >= ALIAS0_IDX) && (word <= ALIAS5_IDX);
    s.stat_hit  = clean && (word == STATUS_IDX);
    s.idx       = 3'(word - ALIAS0_IDX);
    return s;
  endfunction

endpackage

// file: verification/rad_decoder_top_tb.sv
// Self-checking bench for the remote alias decoder
`timescale 1ns/10ps
module rad_decoder_top_tb;
  import rad_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                        aclk, aresetn, rem_ack;
  logic [31:0]                 awaddr, wdata, araddr, rdata;
  logic [3:0]                  wstrb, rem_delay;
  logic [1:0]                  bresp, rresp;
  logic                        awvalid, awready, wvalid, wready, bvalid, bready;
  logic                        arvalid, arready, rvalid, rready;
  logic                        txn_valid, txn_ready, txn_read, la_valid, la;
  logic [6:0]                  txn_addr, bcc_addr, pass_addr;
  logic [NUM_ENTRIES-1:0][6:0] phys;
  logic                        bcc_valid, bcc_ready, bcc_read, rsp_valid, rsp_ack, pass_valid;
  logic [2:0]                  bcc_entry;
  logic [7:0]                  ent [NUM_ENTRIES];
  int                          num_errors, n_compared, cyc;

  rad_decoder_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .txn_valid(txn_valid),
    .txn_ready(txn_ready), .txn_addr(txn_addr), .txn_read(txn_read),
    .physical_target_addr_entry(phys), .bcc_valid(bcc_valid), .bcc_ready(bcc_ready),
    .bcc_addr(bcc_addr), .bcc_read(bcc_read), .bcc_entry(bcc_entry),
    .bcc_resp_valid(rsp_valid), .bcc_resp_ack(rsp_ack), .local_ack_valid(la_valid),
    .local_ack(la), .pass_valid(pass_valid), .pass_addr(pass_addr));

  rad_remote_model remote (
    .aclk(aclk), .aresetn(aresetn), .bcc_valid(bcc_valid), .delay(rem_delay),
    .ack_cfg(rem_ack), .bcc_ready(bcc_ready), .bcc_resp_valid(rsp_valid),
    .bcc_resp_ack(rsp_ack));

  // ---------------------------------------------------------------
  // Clock, watchdog, report
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // The full run needs about 260 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ---------------------------------------------------------------
  // Bus and transaction drivers
  // ---------------------------------------------------------------
  function automatic logic [31:0] adr(input int i);
    return {22'h0, ALIAS0_IDX + 8'(i), 2'h0};
  endfunction

  task automatic wr_chk(input logic [31:0] a, input logic [7:0] d, input logic s,
                        input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= {3'h0, s};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk("rdata", {24'h0, ed}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
  endtask

  // hit_i is the entry expected to match, or -1 for none
  task automatic txn(input logic [6:0] a, input logic rd, input int hit_i);
    logic hit;
    logic autoa;
    logic last;
    int   n;
    hit   = (hit_i >= 0);
    autoa = hit ? (ent[hit_i][AUTOACK_BIT] && !rd) : 1'b0;
    n     = 0;
    @(posedge aclk);
    txn_valid <= 1'b1;
    txn_addr  <= a;
    txn_read  <= rd;
    do @(posedge aclk); while (!txn_ready);
    txn_valid <= 1'b0;
    @(posedge aclk);
    chk("pass_valid", 32'(!hit), 32'(pass_valid));
    if (!hit) chk("pass_addr", 32'(a), 32'(pass_addr));
    chk("bcc_valid", 32'(hit), 32'(bcc_valid));
    if (hit) begin
      chk("bcc_addr", 32'(phys[hit_i]), 32'(bcc_addr));
      chk("bcc_entry", 32'(hit_i), 32'(bcc_entry));
      chk("bcc_read", 32'(rd), 32'(bcc_read));
    end
    chk("auto_ack", 32'(autoa), 32'(la_valid && la));
    repeat (40) begin
      if (txn_ready) break;
      @(posedge aclk);
      if (la_valid) begin
        n++;
        last = la;
      end
    end
    chk("late_acks", 32'(hit && !autoa), 32'(n));
    if (hit && !autoa) chk("local_ack", 32'(rem_ack), 32'(last));
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < NUM_ENTRIES; i++) rd_chk(adr(i), 8'h00, RESP_OKAY);
    txn(7'h00, 1'b0, -1);
  endtask

  task automatic t_regs();
    for (int i = 0; i < NUM_ENTRIES; i++) wr_chk(adr(i), ent[i], 1'b1, RESP_OKAY);
    for (int i = 0; i < NUM_ENTRIES; i++) rd_chk(adr(i), ent[i], RESP_OKAY);
    wr_chk(32'h1ac, 8'h55, 1'b1, RESP_SLVERR);
    rd_chk(32'h1ac, 8'h00, RESP_SLVERR);
    wr_chk(32'h195, 8'h55, 1'b1, RESP_SLVERR);
    wr_chk(adr(0), 8'h00, 1'b0, RESP_OKAY);
    rd_chk(adr(0), ent[0], RESP_OKAY);
  endtask

  task automatic t_match();
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      rem_ack   <= 1'(i % 2);
      rem_delay <= 4'(i);
      txn(ent[i][7:1], 1'b0, i);
      txn(ent[i][7:1], 1'b1, i);
    end
    txn(7'h11, 1'b0, -1);
  endtask

  task automatic t_disable();
    ent[0] = 8'h01;
    ent[2] = 8'h00;
    ent[3] = 8'h67;
    wr_chk(adr(0), ent[0], 1'b1, RESP_OKAY);
    wr_chk(adr(2), ent[2], 1'b1, RESP_OKAY);
    txn(7'h00, 1'b0, -1);
    txn(7'h33, 1'b0, -1);
    wr_chk(adr(3), ent[3], 1'b1, RESP_OKAY);
    txn(7'h33, 1'b0, 3);
    // Status is read only: idle, last hit on entry 3
    wr_chk({22'h0, STATUS_IDX, 2'h0}, 8'hff, 1'b1, RESP_OKAY);
    rd_chk({22'h0, STATUS_IDX, 2'h0}, 8'h16, RESP_OKAY);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, txn_valid, txn_read} = '0;
    {awaddr, wdata, araddr, wstrb, txn_addr, rem_delay, rem_ack} = '0;
    phys = {7'h5a, 7'h4b, 7'h3c, 7'h2d, 7'h1e, 7'h0f};
    ent  = '{8'h21, 8'h44, 8'h67, 8'h8a, 8'had, 8'hff};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_match();
    t_disable();
    end_of_test();
  end
endmodule

// file: verification/rad_remote_model.sv
// Behavioural far-side serializer answering forwarded transactions
`timescale 1ns/10ps
module rad_remote_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       bcc_valid,
  input  wire logic [3:0] delay,
  input  wire logic       ack_cfg,
  output logic            bcc_ready,
  output logic            bcc_resp_valid,
  output logic            bcc_resp_ack
);
  // ---------------------------------------------------------------
  // Accept after delay cycles, answer after delay more
  // ---------------------------------------------------------------
  logic [1:0] st_q;
  logic [3:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q           <= 2'h0;
      cnt_q          <= 4'h0;
      bcc_ready      <= 1'b0;
      bcc_resp_valid <= 1'b0;
      bcc_resp_ack   <= 1'b0;
    end else begin
      bcc_ready      <= 1'b0;
      bcc_resp_valid <= 1'b0;
      // Toggles between answers so a stale level never passes for a fresh one
      bcc_resp_ack   <= ~bcc_resp_ack;
      case (st_q)
        2'h0: begin
          if (bcc_valid) begin
            cnt_q <= delay;
            st_q  <= 2'h1;
          end
        end
        2'h1: begin
          if (cnt_q == 4'h0) begin
            bcc_ready <= 1'b1;
            cnt_q     <= delay;
            st_q      <= 2'h2;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          if (cnt_q == 4'h0) begin
            bcc_resp_valid <= 1'b1;
            bcc_resp_ack   <= ack_cfg;
            st_q           <= 2'h0;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end
endmodule
